// ==== design/ccmc_defs.svh ====
`ifndef CCMC_DEFS_SVH
`define CCMC_DEFS_SVH

// Register byte offsets
`define CCMC_OFS_CLOCK 4'h0
`define CCMC_OFS_POWER 4'h4
`define CCMC_OFS_STATUS 4'h8

// Clock register fields
`define CCMC_CLK_PLL 0
`define CCMC_CLK_MS 1
`define CCMC_CLK_SRC 5:2
`define CCMC_CLK_FS 9:6
`define CCMC_CLK_PS 11:10
`define CCMC_CLK_MASTER_CLOCK_OUTPUT 12
`define CCMC_CLK_BIT_CLOCK_RATIO_SELECT 13
`define CCMC_CLK_W 14
`define CCMC_CLK_RST 14'h0000

// Power register fields
`define CCMC_PWR_VREF 0
`define CCMC_PWR_DAC 1
`define CCMC_PWR_ADL 2
`define CCMC_PWR_ADR 3
`define CCMC_PWR_INIT 5:4
`define CCMC_PWR_W 6
`define CCMC_PWR_RST 6'h00

// Status register fields
`define CCMC_ST_MODE 2:0
`define CCMC_ST_MCLK 3
`define CCMC_ST_VALID 4
`define CCMC_ST_MASTER_CLOCK_OUTPUT_BAD 5
`define CCMC_ST_DRIVE 6
`define CCMC_ST_FRAME 7
`define CCMC_ST_BCLK 8

// PLL source codes that take the bit clock as reference
`define CCMC_SRC_BCLK32 4'h2
`define CCMC_SRC_BCLK64 4'h3

// Sample rate codes above 48 kHz (no mic clock there)
`define CCMC_FS_64K 4'hA
`define CCMC_FS_96K 4'hB
`define CCMC_FS_88K 4'hF

// Master clock to frame ratios, in master clock cycles
`define CCMC_RATIO_PLL 11'h200
`define CCMC_RATIO_256 11'h100
`define CCMC_RATIO_384 11'h180
`define CCMC_RATIO_512 11'h200
`define CCMC_RATIO_1024 11'h400

// Half period of the output clock at 32fs, PLL ratio
`define CCMC_MASTER_CLOCK_OUTPUT_HALF32 4'h8

// Frame edges from converter power-up to valid output: 1059, 267, 2115
`define CCMC_INIT_CNT_00 12'h423
`define CCMC_INIT_CNT_01 12'h10B
`define CCMC_INIT_CNT_1X 12'h843

// Timing
`define CCMC_CLK_PERIOD_NS 10
`define CCMC_PDN_MIN_NS 150
`define CCMC_MCLK_LOSS_CYC 8'h40

`endif

// ==== design/ccmc_pkg.sv ====
`include "ccmc_defs.svh"

package ccmc_pkg;

    typedef enum logic [2:0] {
        PLL_MASTER,
        PLL_SLAVE_MCLK,
        PLL_SLAVE_BCLK,
        EXT_SLAVE,
        EXT_MASTER
    } ccmc_mode_t;

    // Clock mode from the enable, master and source bits
    function automatic ccmc_mode_t decode_mode(input logic pll_en, input logic master, input logic [3:0] src);
        if (!pll_en) begin
            decode_mode = master ? EXT_MASTER : EXT_SLAVE;
        end else if (master) begin
            decode_mode = PLL_MASTER;
        end else if (src == `CCMC_SRC_BCLK32 || src == `CCMC_SRC_BCLK64) begin
            decode_mode = PLL_SLAVE_BCLK;
        end else begin
            decode_mode = PLL_SLAVE_MCLK;
        end
    endfunction : decode_mode

endpackage : ccmc_pkg

// ==== design/ccmc_sync.sv ====
`timescale 1ns/1ps

// Two-stage level synchroniser; the first stage feeds only the second
module ccmc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    // Plain flops, no reset, so a stuck level clears in two edges
    always_ff @(posedge clk) begin
        meta_q <= d;
        q <= meta_q;
    end

endmodule : ccmc_sync

// ==== design/ccmc_clk_div.sv ====
`timescale 1ns/1ps

// Toggle divider: output flips every half cycles, restart aligns it low
module ccmc_clk_div #(
    parameter int W = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic restart,
    input wire logic [W-1:0] half,
    output logic clk_o
);

    logic [W-1:0] cnt_q;

    // Restart wins so every derived clock stays phase-locked to the frame
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
            clk_o <= 1'b0;
        end else if (ce) begin
            if (restart) begin
                cnt_q <= '0;
                clk_o <= 1'b0;
            end else if (cnt_q >= half - W'(1)) begin
                cnt_q <= '0;
                clk_o <= ~clk_o;
            end else begin
                cnt_q <= cnt_q + W'(1);
            end
        end
    end

endmodule : ccmc_clk_div

// ==== design/ccmc_clock_mode.sv ====
`timescale 1ns/1ps
`include "ccmc_defs.svh"

module ccmc_clock_mode (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic master_clock_input,
    input wire logic power_down_pin_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic bit_clock_in,
    output logic bit_clock_out,
    output logic bit_clock_oe,
    input wire logic frame_clock_in,
    output logic frame_clock_out,
    output logic frame_clock_oe,
    output logic master_clock_output,
    output logic digital_mic_clock,
    output logic adc_output_valid
);

    localparam int PDN_CYC = (`CCMC_PDN_MIN_NS + `CCMC_CLK_PERIOD_NS - 1) / `CCMC_CLK_PERIOD_NS;

    // Byte-enable mask for a word write
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : be_mask

    // Master clock cycles per frame
    function automatic logic [10:0] frame_ratio(input logic pll_en, input logic [1:0] fs);
        if (pll_en) begin
            frame_ratio = `CCMC_RATIO_PLL;
        end else begin
            case (fs)
                2'h0: frame_ratio = `CCMC_RATIO_256;
                2'h1: frame_ratio = `CCMC_RATIO_384;
                2'h2: frame_ratio = `CCMC_RATIO_512;
                default: frame_ratio = `CCMC_RATIO_1024;
            endcase
        end
    endfunction : frame_ratio

    // ---------------- Bus side, ref_clk ----------------
    logic [`CCMC_CLK_W-1:0] clk_q;
    logic [`CCMC_PWR_W-1:0] pwr_q;
    logic [4:0] pin_s;
    logic pdn_n_s, frame_in_s, bclk_in_s, frame_gen_s, hb_s;
    logic [4:0] pdn_cnt_q;
    logic srst;
    logic wr_take;
    logic [31:0] status;
    ccmc_pkg::ccmc_mode_t mode_q;
    logic hb_prev_q, hb_q;
    logic [7:0] loss_cnt_q;
    logic mclk_present_q;
    logic drive_q;
    logic master_clock_output_bad_q;
    logic fsrc, fsrc_prev_q, frame_rise;
    logic adc_on, adc_on_prev_q, counting_q;
    logic [11:0] fcount_q, target;

    ccmc_sync #(.W(5)) u_pin_sync (
        .clk(ref_clk),
        .d({power_down_pin_n, frame_clock_in, bit_clock_in, frame_clock_out, hb_q}),
        .q(pin_s)
    );
    assign {pdn_n_s, frame_in_s, bclk_in_s, frame_gen_s, hb_s} = pin_s;

    // Power-down pin must stay low PDN_CYC cycles; shorter glitches are ignored
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pdn_cnt_q <= '0;
        end else if (clk_en) begin
            if (pdn_n_s) begin
                pdn_cnt_q <= '0;
            end else if (pdn_cnt_q != 5'(PDN_CYC)) begin
                pdn_cnt_q <= pdn_cnt_q + 5'h01;
            end
        end
    end
    assign srst = reset || (pdn_cnt_q == 5'(PDN_CYC));

    assign wr_take = avs_write && !avs_waitrequest;

    // Control registers; master bit clears to slave on any reset
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            clk_q <= `CCMC_CLK_RST;
            pwr_q <= `CCMC_PWR_RST;
        end else if (clk_en && wr_take) begin
            case (avs_address)
                `CCMC_OFS_CLOCK: clk_q <= (clk_q & ~`CCMC_CLK_W'(be_mask(avs_byteenable)))
                    | `CCMC_CLK_W'(avs_writedata & be_mask(avs_byteenable));
                `CCMC_OFS_POWER: pwr_q <= (pwr_q & ~`CCMC_PWR_W'(be_mask(avs_byteenable)))
                    | `CCMC_PWR_W'(avs_writedata & be_mask(avs_byteenable));
                default: ;
            endcase
        end
    end

    // Status word; reserved bits read zero
    always_comb begin
        status = 32'h0000_0000;
        status[`CCMC_ST_MODE] = 3'(mode_q);
        status[`CCMC_ST_MCLK] = mclk_present_q;
        status[`CCMC_ST_VALID] = adc_output_valid;
        status[`CCMC_ST_MASTER_CLOCK_OUTPUT_BAD] = master_clock_output_bad_q;
        status[`CCMC_ST_DRIVE] = drive_q;
        status[`CCMC_ST_FRAME] = frame_in_s;
        status[`CCMC_ST_BCLK] = bclk_in_s;
    end

    // One wait cycle per access; unmapped reads return zero
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                case (avs_address)
                    `CCMC_OFS_CLOCK: avs_readdata <= 32'(clk_q);
                    `CCMC_OFS_POWER: avs_readdata <= 32'(pwr_q);
                    `CCMC_OFS_STATUS: avs_readdata <= status;
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end else begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    // Mode, output-clock health and clock-pin drive flags
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_q <= ccmc_pkg::EXT_SLAVE;
            master_clock_output_bad_q <= 1'b0;
            drive_q <= 1'b0;
        end else if (clk_en) begin
            mode_q <= ccmc_pkg::decode_mode(clk_q[`CCMC_CLK_PLL], clk_q[`CCMC_CLK_MS], clk_q[`CCMC_CLK_SRC]);
            master_clock_output_bad_q <= clk_q[`CCMC_CLK_MS] && clk_q[`CCMC_CLK_MASTER_CLOCK_OUTPUT] && !clk_q[`CCMC_CLK_PLL];
            drive_q <= pwr_q[`CCMC_PWR_VREF] && clk_q[`CCMC_CLK_MS] && mclk_present_q;
        end
    end

    // Master clock presence from the link heartbeat; a stopped clock times out
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hb_prev_q <= 1'b0;
            loss_cnt_q <= `CCMC_MCLK_LOSS_CYC;
            mclk_present_q <= 1'b0;
        end else if (clk_en) begin
            hb_prev_q <= hb_s;
            if (hb_s != hb_prev_q) begin
                loss_cnt_q <= 8'h00;
            end else if (loss_cnt_q != `CCMC_MCLK_LOSS_CYC) begin
                loss_cnt_q <= loss_cnt_q + 8'h01;
            end
            mclk_present_q <= (loss_cnt_q != `CCMC_MCLK_LOSS_CYC);
        end
    end

    // Frame edges come from our own clock as master, else from the pin
    assign fsrc = clk_q[`CCMC_CLK_MS] ? frame_gen_s : frame_in_s;
    assign frame_rise = fsrc && !fsrc_prev_q;
    assign adc_on = pwr_q[`CCMC_PWR_ADL] || pwr_q[`CCMC_PWR_ADR];

    always_comb begin
        case (pwr_q[`CCMC_PWR_INIT])
            2'h0: target = `CCMC_INIT_CNT_00;
            2'h1: target = `CCMC_INIT_CNT_01;
            default: target = `CCMC_INIT_CNT_1X;
        endcase
    end

    // Converter start-up: count frame rising edges after the first power bit
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fsrc_prev_q <= 1'b0;
            adc_on_prev_q <= 1'b0;
            counting_q <= 1'b0;
            fcount_q <= 12'h000;
            adc_output_valid <= 1'b0;
        end else if (clk_en) begin
            fsrc_prev_q <= fsrc;
            adc_on_prev_q <= adc_on;
            if (!adc_on) begin
                counting_q <= 1'b0;
                adc_output_valid <= 1'b0;
            end else if (!adc_on_prev_q) begin
                counting_q <= 1'b1;
                fcount_q <= 12'h000;
                adc_output_valid <= 1'b0;
            end else if (counting_q && frame_rise) begin
                fcount_q <= fcount_q + 12'h001;
                if (fcount_q == target - 12'h001) begin
                    counting_q <= 1'b0;
                    adc_output_valid <= 1'b1;
                end
            end
        end
    end

    // ---------------- Link side, master clock ----------------
    // Config crosses as quasi-static levels; a change mid-frame may glitch one period
    logic [15:0] cfg_s;
    logic lrst_s;
    logic l_drive, l_pll, l_ms, l_master_clock_output_en, l_bit_clock_ratio_select, l_ce;
    logic [3:0] l_src, l_fs;
    logic [1:0] l_ps;
    logic [10:0] l_ratio, fcnt_q;
    logic restart, bdiv, ddiv, mdiv, dmic_ok, master_clock_output_ok;
    ccmc_pkg::ccmc_mode_t l_mode;

    ccmc_sync #(.W(16)) u_cfg_sync (
        .clk(master_clock_input),
        .d({drive_q, clk_q[`CCMC_CLK_PLL], clk_q[`CCMC_CLK_MS], clk_q[`CCMC_CLK_SRC], clk_q[`CCMC_CLK_FS],
            clk_q[`CCMC_CLK_PS], clk_q[`CCMC_CLK_MASTER_CLOCK_OUTPUT], clk_q[`CCMC_CLK_BIT_CLOCK_RATIO_SELECT], clk_en}),
        .q(cfg_s)
    );
    assign {l_drive, l_pll, l_ms, l_src, l_fs, l_ps, l_master_clock_output_en, l_bit_clock_ratio_select, l_ce} = cfg_s;

    ccmc_sync #(.W(1)) u_rst_sync (
        .clk(master_clock_input),
        .d(srst),
        .q(lrst_s)
    );

    assign l_mode = ccmc_pkg::decode_mode(l_pll, l_ms, l_src);
    assign l_ratio = frame_ratio(l_pll, l_fs[1:0]);
    assign restart = (fcnt_q == 11'h000);
    assign dmic_ok = !(l_fs == `CCMC_FS_64K || l_fs == `CCMC_FS_96K || l_fs == `CCMC_FS_88K);
    assign master_clock_output_ok = l_master_clock_output_en && (l_mode == ccmc_pkg::PLL_MASTER || l_mode == ccmc_pkg::PLL_SLAVE_MCLK);

    // Frame counter; one wrap is one sample period
    always_ff @(posedge master_clock_input) begin
        if (lrst_s) begin
            fcnt_q <= 11'h000;
            hb_q <= 1'b0;
        end else if (l_ce) begin
            hb_q <= ~hb_q;
            fcnt_q <= (fcnt_q >= l_ratio - 11'h001) ? 11'h000 : fcnt_q + 11'h001;
        end
    end

    ccmc_clk_div #(.W(11)) u_bclk_div (
        .clk(master_clock_input),
        .rst(lrst_s),
        .ce(l_ce),
        .restart(restart),
        .half(l_bit_clock_ratio_select ? (l_ratio >> 7) : (l_ratio >> 6)),
        .clk_o(bdiv)
    );

    ccmc_clk_div #(.W(11)) u_dmic_div (
        .clk(master_clock_input),
        .rst(lrst_s),
        .ce(l_ce),
        .restart(restart),
        .half(l_ratio >> 7),
        .clk_o(ddiv)
    );

    ccmc_clk_div #(.W(4)) u_master_clock_output_div (
        .clk(master_clock_input),
        .rst(lrst_s),
        .ce(l_ce),
        .restart(restart),
        .half(`CCMC_MASTER_CLOCK_OUTPUT_HALF32 >> l_ps),
        .clk_o(mdiv)
    );

    // Pin outputs; a released bit clock output rests low, the frame output keeps running as the internal frame source
    always_ff @(posedge master_clock_input) begin
        if (lrst_s) begin
            bit_clock_out <= 1'b0;
            bit_clock_oe <= 1'b0;
            frame_clock_out <= 1'b0;
            frame_clock_oe <= 1'b0;
            master_clock_output <= 1'b0;
            digital_mic_clock <= 1'b0;
        end else if (l_ce) begin
            bit_clock_oe <= l_drive;
            frame_clock_oe <= l_drive;
            bit_clock_out <= l_drive && bdiv;
            frame_clock_out <= fcnt_q < (l_ratio >> 1);
            master_clock_output <= master_clock_output_ok && mdiv;
            digital_mic_clock <= dmic_ok && ddiv;
        end
    end

    // ---------------- Checks ----------------
    sequence s_pdn_held;
        !pdn_n_s [*2] ##1 (pdn_cnt_q == 5'(PDN_CYC));
    endsequence

    sequence s_adc_power_up;
        !adc_on ##1 (adc_on && clk_en);
    endsequence

    a_reset_slave: assert property (@(posedge ref_clk) reset |=> !clk_q[`CCMC_CLK_MS])
        else $error("master bit not cleared by reset");
    a_ext_master_mode: assert property (@(posedge ref_clk) disable iff (srst)
        (clk_en && !clk_q[`CCMC_CLK_PLL] && clk_q[`CCMC_CLK_MS]) |=> mode_q == ccmc_pkg::EXT_MASTER)
        else $error("external master mode not decoded");
    a_pdn_resets: assert property (@(posedge ref_clk) disable iff (reset)
        s_pdn_held |=> (clk_q == `CCMC_CLK_RST && pwr_q == `CCMC_PWR_RST))
        else $error("power-down pin did not reset registers");
    a_master_clock_output_bad_flag: assert property (@(posedge ref_clk) disable iff (srst)
        (clk_en && clk_q[`CCMC_CLK_MS] && clk_q[`CCMC_CLK_MASTER_CLOCK_OUTPUT] && !clk_q[`CCMC_CLK_PLL]) |=> master_clock_output_bad_q)
        else $error("unusable output clock not flagged");
    a_adc_valid_count: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(adc_output_valid) |-> ($past(fcount_q) == $past(target) - 12'h001 && $past(frame_rise)))
        else $error("converter output valid at wrong frame count");
    a_adc_restart: assert property (@(posedge ref_clk) disable iff (srst)
        s_adc_power_up |=> (!adc_output_valid && fcount_q == 12'h000))
        else $error("converter start-up count not restarted");
    a_master_clock_output_low_off: assert property (@(posedge master_clock_input) disable iff (lrst_s)
        (l_ce && !l_master_clock_output_en) |=> !master_clock_output)
        else $error("output clock active while disabled");
    a_master_clock_output_ext_master: assert property (@(posedge master_clock_input) disable iff (lrst_s)
        (l_ce && l_mode == ccmc_pkg::EXT_MASTER) |=> !master_clock_output)
        else $error("output clock active in external master mode");
    a_drive_pins: assert property (@(posedge master_clock_input) disable iff (lrst_s)
        (l_ce && l_drive) |=> (bit_clock_oe && frame_clock_oe))
        else $error("master clocks not driven");
    a_slave_release: assert property (@(posedge master_clock_input) disable iff (lrst_s)
        (l_ce && !l_ms) [*3] |=> (!bit_clock_oe && !frame_clock_oe))
        else $error("clock pins driven in slave mode");
    a_dmic_off: assert property (@(posedge master_clock_input) disable iff (lrst_s)
        (l_ce && !dmic_ok) |=> !digital_mic_clock)
        else $error("mic clock running above 48 kHz");

endmodule : ccmc_clock_mode

// ==== tb/ccmc_far_side.sv ====
`timescale 1ns/1ps

// Far-side audio processor: supplies the master clock and the slave-mode bit and frame clocks
module ccmc_far_side (
    input wire logic run,
    input wire logic [10:0] ratio,
    output logic master_clock_input,
    output logic bit_clock,
    output logic frame_clock
);
    logic [10:0] cnt_q;

    // 80 ns clock with an odd start offset; when stopped it is tied low
    initial begin
        master_clock_input = 1'b0;
        bit_clock = 1'b0;
        cnt_q = 11'h000;
        #3;
        forever begin
            #40;
            master_clock_input = run ? ~master_clock_input : 1'b0;
        end
    end

    // One frame is ratio master clocks, high in the first half
    always @(posedge master_clock_input) begin
        cnt_q <= (cnt_q + 11'h001 >= ratio) ? 11'h000 : cnt_q + 11'h001;
    end
    assign frame_clock = cnt_q < (ratio >> 1);

    // Bit edges lag master edges by 20 ns, so they never meet a frame edge
    always @(master_clock_input) begin
        bit_clock <= #20 ~bit_clock;
    end
endmodule : ccmc_far_side

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps

module tb_top;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic power_down_pin_n = 1'b1;
    logic mclk_run = 1'b1;
    logic clk_en = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [10:0] ratio = 11'h020;
    logic mclk, far_bit, far_frame, bit_w, frame_w;
    logic bit_out, bit_oe, frame_out, frame_oe, mco, mic, valid;
    logic [31:0] rd;
    int bad_count = 0;
    int total_checks = 0;
    int seed = 36;
    int m_clk = 0;
    int m_pwr = 0;
    int p, c, n, cnt;
    logic prev;

    always #5 ref_clk = ~ref_clk;

    // Pin level: the device wins while its enable is high
    assign bit_w = bit_oe ? bit_out : far_bit;
    assign frame_w = frame_oe ? frame_out : far_frame;

    ccmc_far_side far (.run(mclk_run), .ratio(ratio), .master_clock_input(mclk),
        .bit_clock(far_bit), .frame_clock(far_frame));

    ccmc_clock_mode uut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .master_clock_input(mclk),
        .power_down_pin_n(power_down_pin_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bit_clock_in(bit_w),
        .bit_clock_out(bit_out), .bit_clock_oe(bit_oe), .frame_clock_in(frame_w),
        .frame_clock_out(frame_out), .frame_clock_oe(frame_oe), .master_clock_output(mco),
        .digital_mic_clock(mic), .adc_output_valid(valid));

    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    // One Avalon access; the register model follows every completed write
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        avs_write <= wr;
        avs_read <= ~wr;
        avs_address <= a;
        avs_writedata <= d;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (k >= 50) chk("bus answer", 0, 1);
        if (wr && a == 4'h0) m_clk = d & 32'h00003FFF;
        if (wr && a == 4'h4) m_pwr = d & 32'h0000003F;
    endtask : bus

    function int mode_of(input int v);
        if (v[0] == 1'b0) return v[1] ? 4 : 3;
        if (v[1]) return 0;
        return (v[5:2] == 2 || v[5:2] == 3) ? 2 : 1;
    endfunction : mode_of

    function logic pick(input int s);
        case (s)
            0: pick = frame_out;
            1: pick = bit_out;
            2: pick = mco;
            default: pick = mic;
        endcase
    endfunction : pick

    // Master clocks between two rising edges of a derived clock
    task period(input int s, output int q);
        logic was, now;
        int k;
        q = -1;
        was = 1'b1;
        for (k = 0; k < 2500; k++) begin
            @(posedge mclk);
            now = pick(s);
            if (now === 1'b1 && was === 1'b0) begin
                if (q >= 0) break;
                q = 0;
            end
            if (q >= 0) q++;
            was = now;
        end
    endtask : period

    // Settle, then count master clocks with the output high
    task quiet(input int s, input string what);
        int k, hits;
        hits = 0;
        repeat (20) @(posedge mclk);
        for (k = 0; k < 200; k++) begin
            @(posedge mclk);
            if (pick(s) !== 1'b0) hits++;
        end
        chk(what, 0, hits);
    endtask : quiet

    task status(input string what, input int exp, input int lsb, input int w);
        bus(1'b0, 4'h8, 32'h00000000);
        chk(what, exp, (rd >> lsb) & ((1 << w) - 1));
    endtask : status

    // Watchdog just above the longest expected run, start-up count dominates
    initial begin
        repeat (110000) @(posedge ref_clk);
        bad_count++;
        end_sim();
    end

    initial begin
        repeat (4) @(posedge mclk);
        @(posedge ref_clk);
        reset <= 1'b0;
        bus(1'b0, 4'h0, 0); chk("clock reg", 0, rd);
        bus(1'b0, 4'h4, 0); chk("power reg", 0, rd);
        status("mode", 3, 0, 3);
        chk("frame oe", 0, frame_oe);
        bus(1'b1, 4'hC, 32'h0000FFFF);
        bus(1'b0, 4'hC, 0); chk("unmapped", 0, rd);
        bus(1'b0, 4'h0, 0); chk("clock reg", m_clk, rd);
        $display("test reset done");

        // Source programmed before the enable rises, upper bits random
        for (int i = 0; i < 12; i++) begin
            c = (i & 3) | ((i < 8 ? 2 + i / 4 : $random(seed) & 15) << 2);
            bus(1'b1, 4'h0, c & ~1);
            bus(1'b1, 4'h0, c | ($random(seed) << 14));
            bus(1'b0, 4'h0, 0); chk("clock reg", m_clk, rd);
            status("mode", mode_of(m_clk), 0, 3);
        end
        $display("test modes done");

        // External master at 256fs and 384fs, output clock requested
        bus(1'b1, 4'h4, 1);
        for (int j = 0; j < 2; j++) begin
            bus(1'b1, 4'h0, 2 | (j << 6) | 32'h1000 | (j << 13));
            for (n = 0; n < 400 && !(frame_oe === 1'b1 && bit_oe === 1'b1); n++) @(posedge ref_clk);
            chk("clock drive", 2'b11, {frame_oe, bit_oe});
            repeat (20) @(posedge mclk);
            period(0, p); chk("frame period", j ? 384 : 256, p);
            period(1, p); chk("bit period", j ? 6 : 8, p);
            quiet(2, "ext clock out");
            status("unusable", 1, 5, 1);
        end
        $display("test ext master done");

        // PLL master at 512fs, 48 kHz
        bus(1'b1, 4'h0, 32'h252);
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, 4'h0, 32'h1253 | (s << 10));
            repeat (20) @(posedge mclk);
            period(2, p); chk("clock out period", 2 * (8 >> s), p);
        end
        period(3, p); chk("mic period", 8, p);
        period(0, p); chk("frame period", 512, p);
        status("unusable", 0, 5, 1);
        status("mode", 0, 0, 3);
        bus(1'b1, 4'h0, 32'h253);
        quiet(2, "clock out off");
        bus(1'b1, 4'h0, 32'h2D3);
        quiet(3, "mic off");
        $display("test pll master done");

        // Bit-clock PLL slave with the master clock tied low
        bus(1'b1, 4'h0, 32'h8);
        bus(1'b1, 4'h0, 32'h9);
        mclk_run <= 1'b0;
        repeat (200) @(posedge ref_clk);
        status("mode", 2, 0, 3);
        status("mclk present", 0, 3, 1);
        mclk_run <= 1'b1;
        repeat (100) @(posedge ref_clk);
        $display("test bclk slave done");

        // Start-up count, shortened frames from the far side
        bus(1'b1, 4'h0, 0);
        bus(1'b1, 4'h4, 32'h15);
        cnt = 0;
        prev = frame_w;
        for (n = 0; n < 80000 && cnt < 269; n++) begin
            @(posedge ref_clk);
            if (frame_w === 1'b1 && prev === 1'b0) begin
                cnt++;
                if (cnt == 265) chk("early valid", 0, valid);
            end
            prev = frame_w;
        end
        chk("valid", 1, valid);
        bus(1'b1, 4'h4, 1);
        repeat (20) @(posedge ref_clk);
        chk("valid off", 0, valid);
        $display("test startup done");

        // Power-down pin low for 200 ns
        bus(1'b1, 4'h0, 3);
        @(posedge ref_clk);
        power_down_pin_n <= 1'b0;
        repeat (20) @(posedge ref_clk);
        power_down_pin_n <= 1'b1;
        repeat (10) @(posedge ref_clk);
        m_clk = 0;
        m_pwr = 0;
        bus(1'b0, 4'h0, 0); chk("clock after pdn", m_clk, rd);
        bus(1'b0, 4'h4, 0); chk("power after pdn", m_pwr, rd);
        status("mode after pdn", 3, 0, 3);
        $display("test power down done");

        // Clock enable low freezes the link outputs
        clk_en <= 1'b0;
        repeat (10) @(posedge mclk);
        prev = mic;
        cnt = 0;
        repeat (40) begin
            @(posedge mclk);
            if (mic !== prev) cnt++;
            prev = mic;
        end
        chk("frozen mic", 0, cnt);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        $display("test clock enable done");
        end_sim();
    end
endmodule : tb_top
